// ===== logic/sld_driver.sv
// Segment display driver: register file, clock select, frame sequencer,
// blink, pin drive, frame interrupt and low-power wakeup request.
// Assumes a 32-bit AXI4-Lite master, power modes from the system
// controller on aclk, and display clocks that arrive as raw pins.
//
// Functional notes
// - Display clock is the oscillator output or the alternate clock.
// - In stop2 only the oscillator output can clock the display.
// - Stop2 wakeup resets control registers except the clock gate; data registers keep contents.
// - Bus clock gate bit set by reset; clearing it cuts bus access to every register but the gate itself.
// - Stop2 with stop disable set halts driver, else display continues when clocked by the oscillator output.
// - Stop3 with stop disable set halts driver, else display continues.
// - Wait with wait disable set halts driver, else waveforms continue.
// - Frame interrupt never wakes the processor from stop2.
// - Frame interrupt can wake the processor from stop3.
// - Frame interrupt can wake the processor from wait.
// - Each pin is frontplane or backplane; up to eight backplanes.
// - Pin count supports 4x40 or 8x36 arrangements.
// - Blink blanks segments or shows alternate display at duty four or less.
// - Four-bit trim field drives the regulated reference for contrast.
// - Configurable frame interrupt; backplane phases are reassignable.
`timescale 1ns/10ps
`default_nettype none

module sld_driver
    import sld_pkg::*;
#(
    parameter int NPINS = sld_pkg::NUM_PINS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_osc_clock,
    input wire logic alternate_clock,
    input wire sld_pkg::sld_pmode_t pmode,
    input wire logic stop2_wakeup,
    output logic [NPINS-1:0] seg_out,
    output logic [NPINS-1:0] seg_oe,
    output logic [3:0] contrast_trim,
    output logic irq,
    output logic wake_req,
    output logic driver_active
);
    import sld_pkg::*;

    // Register state
    sld_ctrl_t ctrl_r;
    logic int_en_r;
    logic status_r;
    logic clk_gate_r;
    logic [NPINS-1:0] pen_r;
    logic [NPINS-1:0] bpen_r;
    logic [7:0] wf_r [NPINS];

    // Bus channel state
    logic aw_full_r;
    logic w_full_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Write side decode
    wire aw_take = s_axi_awvalid & awready_r;
    wire w_take = s_axi_wvalid & wready_r;
    wire do_write = aw_full_r & w_full_r & ~bvalid_r;
    wire aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
    wire w_full_nxt = (w_full_r | w_take) & ~do_write;
    wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                         {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0] ctrl_wr = (ctrl_r & ~wmask) | (w_data_r & wmask);
    // Only the gate register answers while the bus clock is gated off
    wire bus_on = clk_gate_r;
    wire wf_hit_w = (aw_addr_r >= OFF_WF_BASE) &&
        (aw_addr_r < OFF_WF_BASE + 12'(NPINS * 4));
    wire [5:0] wf_idx_w = 6'((aw_addr_r - OFF_WF_BASE) >> 2);
    wire wr_ctrl = do_write & bus_on & (aw_addr_r == OFF_CTRL);
    wire wr_clr = do_write & bus_on & (aw_addr_r == OFF_INT_CLR);
    wire wr_ien = do_write & bus_on & (aw_addr_r == OFF_INT_EN);
    wire wr_gate = do_write & (aw_addr_r == OFF_CLK_GATE);
    wire wr_pl = do_write & bus_on & (aw_addr_r == OFF_PEN_LO);
    wire wr_ph = do_write & bus_on & (aw_addr_r == OFF_PEN_HI);
    wire wr_bl = do_write & bus_on & (aw_addr_r == OFF_BPEN_LO);
    wire wr_bh = do_write & bus_on & (aw_addr_r == OFF_BPEN_HI);
    wire wr_wf = do_write & bus_on & wf_hit_w & w_strb_r[0];
    wire wr_ok = wr_ctrl | wr_clr | wr_ien | wr_gate | wr_pl | wr_ph |
        wr_bl | wr_bh | (do_write & bus_on & wf_hit_w) |
        (do_write & bus_on & (aw_addr_r == OFF_STATUS)) |
        (do_write & bus_on & (aw_addr_r == OFF_STATE));

    // Read side decode
    wire ar_take = s_axi_arvalid & arready_r;
    wire rvalid_nxt = (rvalid_r & ~s_axi_rready) | ar_take;
    wire [11:0] ra = s_axi_araddr[11:0];
    wire rd_hi_ok = (s_axi_araddr[31:12] == 20'h00000);
    wire wf_hit_r = (ra >= OFF_WF_BASE) &&
        (ra < OFF_WF_BASE + 12'(NPINS * 4));
    wire [5:0] wf_idx_r = 6'((ra - OFF_WF_BASE) >> 2);
    logic [63:0] pen_x;
    logic [63:0] bpen_x;
    assign pen_x = 64'(pen_r);
    assign bpen_x = 64'(bpen_r);

    // Power and clocking
    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic alt_s1_r, alt_s2_r, alt_s3_r;
    wire osc_tick = osc_s2_r & ~osc_s3_r;
    wire alt_tick = alt_s2_r & ~alt_s3_r;
    // Alternate clock is not available in stop2
    wire clk_tick = ctrl_r.src_alt ? (alt_tick & ~pmode.stop2)
                                   : osc_tick;
    wire in_stop = pmode.stop2 | pmode.stop3;
    wire halt_stop = in_stop & ctrl_r.stop_mode_disable;
    wire halt_wait = pmode.wait_mode & ctrl_r.wait_mode_disable;
    wire running = ctrl_r.enable & ~halt_stop & ~halt_wait;

    // Frame sequencer
    logic [7:0] pre_cnt_r;
    logic [2:0] phase_r;
    logic [7:0] blink_cnt_r;
    logic blink_ph_r;
    wire [7:0] pre_top = 8'((9'h002 << ctrl_r.prescale) - 9'h001);
    wire [7:0] blink_top = 8'((9'h002 << ctrl_r.blink_rate) - 9'h001);
    wire pre_end = running & clk_tick & (pre_cnt_r == pre_top);
    wire frame_end = pre_end & (phase_r >= ctrl_r.duty);
    wire frame_evt = frame_end;
    wire blink_blank = ctrl_r.blink_en & blink_ph_r & ~ctrl_r.blink_alt;
    // Alternate bits only exist when four phases or fewer are in use
    wire blink_alt = ctrl_r.blink_en & blink_ph_r & ctrl_r.blink_alt &
        (ctrl_r.duty <= ALT_MAX_DUTY);
    wire irq_nxt = status_r & int_en_r;
    // Stop2 is never left on a frame event
    wire wake_nxt = irq_nxt & ~pmode.stop2 &
        (pmode.stop3 | pmode.wait_mode);

    // Pin drive, one slice per pin
    logic [NPINS-1:0] pin_val;
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            wire [2:0] alt_ph = phase_r + 3'h4;
            wire [7:0] wfb = wf_r[gi];
            // Backplanes ignore blink, so the common reference stays
            wire fp_val = blink_blank ? 1'b0 :
                blink_alt ? wfb[alt_ph] : wfb[phase_r];
            // A backplane drives in the phases its byte selects
            assign pin_val[gi] = bpen_r[gi] ? wfb[phase_r]
                                            : fp_val;
        end
    endgenerate

    // Bus channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r <= ~w_full_nxt;
            if (aw_take) begin
                aw_addr_r <= (s_axi_awaddr[31:12] == 20'h00000) ?
                    s_axi_awaddr[11:0] : 12'hFFF;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rresp_r <= RESP_OKAY;
                rdata_r <= 32'h0000_0000;
                if (!rd_hi_ok) begin
                    rresp_r <= RESP_SLVERR;
                end else if (ra == OFF_CLK_GATE) begin
                    rdata_r <= {31'h0, clk_gate_r};
                end else if (!bus_on) begin
                    rdata_r <= 32'h0000_0000;
                end else if (ra == OFF_CTRL) begin
                    rdata_r <= ctrl_r;
                end else if (ra == OFF_STATUS) begin
                    rdata_r <= {31'h0, status_r};
                end else if (ra == OFF_INT_CLR) begin
                    rdata_r <= 32'h0000_0000;
                end else if (ra == OFF_INT_EN) begin
                    rdata_r <= {31'h0, int_en_r};
                end else if (ra == OFF_PEN_LO) begin
                    rdata_r <= pen_x[31:0];
                end else if (ra == OFF_PEN_HI) begin
                    rdata_r <= pen_x[63:32];
                end else if (ra == OFF_BPEN_LO) begin
                    rdata_r <= bpen_x[31:0];
                end else if (ra == OFF_BPEN_HI) begin
                    rdata_r <= bpen_x[63:32];
                end else if (ra == OFF_STATE) begin
                    rdata_r <= {24'h0, blink_ph_r, phase_r,
                        pmode, running};
                end else if (wf_hit_r) begin
                    rdata_r <= {24'h0, wf_r[wf_idx_r]};
                end else begin
                    rresp_r <= RESP_SLVERR;
                end
            end
        end
    end

    // Control registers; stop2 wakeup returns all but the clock gate to defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= sld_ctrl_t'(CTRL_RST);
            int_en_r <= INT_EN_RST;
            clk_gate_r <= CLK_GATE_RST;
        end else begin
            if (stop2_wakeup) begin
                ctrl_r <= sld_ctrl_t'(CTRL_RST);
                int_en_r <= INT_EN_RST;
            end else begin
                if (wr_ctrl) begin
                    ctrl_r <= sld_ctrl_t'(ctrl_wr);
                end
                if (wr_ien && w_strb_r[0]) begin
                    int_en_r <= w_data_r[ST_FRAME];
                end
            end
            if (wr_gate && w_strb_r[0]) begin
                clk_gate_r <= w_data_r[0];
            end
        end
    end

    // Data registers are untouched by stop2 wakeup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pen_r <= '0;
            bpen_r <= '0;
        end else begin
            if (wr_pl) begin
                pen_r <= NPINS'((pen_x & ~{32'h0, wmask}) |
                    ({32'h0, w_data_r} & {32'h0, wmask}));
            end else if (wr_ph) begin
                pen_r <= NPINS'((pen_x & ~{wmask, 32'h0}) |
                    ({w_data_r, 32'h0} & {wmask, 32'h0}));
            end
            if (wr_bl) begin
                bpen_r <= NPINS'((bpen_x & ~{32'h0, wmask}) |
                    ({32'h0, w_data_r} & {32'h0, wmask}));
            end else if (wr_bh) begin
                bpen_r <= NPINS'((bpen_x & ~{wmask, 32'h0}) |
                    ({w_data_r, 32'h0} & {wmask, 32'h0}));
            end
        end
    end

    // Waveform store keeps no reset so it survives everything but power
    always_ff @(posedge aclk) begin
        if (wr_wf) begin
            wf_r[wf_idx_w] <= w_data_r[7:0];
        end
    end

    // Status: a frame event in the clear cycle still sets the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 1'b0;
        end else if (frame_evt) begin
            status_r <= 1'b1;
        end else if (wr_clr && w_strb_r[0] && w_data_r[ST_FRAME]) begin
            status_r <= 1'b0;
        end
    end

    // Clock pins pass two flops before the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            alt_s1_r <= 1'b0;
            alt_s2_r <= 1'b0;
            alt_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= external_osc_clock;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            alt_s1_r <= alternate_clock;
            alt_s2_r <= alt_s1_r;
            alt_s3_r <= alt_s2_r;
        end
    end

    // Sequencer freezes while halted and restarts on enable
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_r.enable) begin
            pre_cnt_r <= 8'h00;
            phase_r <= 3'h0;
            blink_cnt_r <= 8'h00;
            blink_ph_r <= 1'b0;
        end else if (running && clk_tick) begin
            pre_cnt_r <= pre_end ? 8'h00 : pre_cnt_r + 8'h01;
            if (frame_end) begin
                phase_r <= 3'h0;
                blink_cnt_r <= (blink_cnt_r == blink_top) ?
                    8'h00 : blink_cnt_r + 8'h01;
                if (blink_cnt_r == blink_top) begin
                    blink_ph_r <= ~blink_ph_r;
                end
            end else if (pre_end) begin
                phase_r <= phase_r + 3'h1;
            end
        end
    end

    // All outputs leave from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seg_out <= '0;
            seg_oe <= '0;
            contrast_trim <= 4'h0;
            irq <= 1'b0;
            wake_req <= 1'b0;
            driver_active <= 1'b0;
        end else begin
            // Halted driver releases every pin
            seg_oe <= running ? pen_r : '0;
            seg_out <= running ? (pin_val & pen_r) : '0;
            contrast_trim <= ctrl_r.trim;
            irq <= irq_nxt;
            wake_req <= wake_nxt;
            driver_active <= running;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule : sld_driver

`default_nettype wire

// ===== logic/sld_pkg.sv
// Shared constants and types for the segment display driver.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package sld_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_INT_CLR = 12'h008;
    localparam logic [11:0] OFF_INT_EN = 12'h00C;
    localparam logic [11:0] OFF_CLK_GATE = 12'h010;
    localparam logic [11:0] OFF_PEN_LO = 12'h014;
    localparam logic [11:0] OFF_PEN_HI = 12'h018;
    localparam logic [11:0] OFF_BPEN_LO = 12'h01C;
    localparam logic [11:0] OFF_BPEN_HI = 12'h020;
    localparam logic [11:0] OFF_STATE = 12'h024;
    // Waveform store: one byte per pin, one word per pin
    localparam logic [11:0] OFF_WF_BASE = 12'h100;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0180;
    localparam logic [0:0] INT_EN_RST = 1'h0;
    localparam logic [0:0] CLK_GATE_RST = 1'h1;

    // Status bit positions
    localparam int ST_FRAME = 0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin and phase limits
    localparam int NUM_PINS = 64;
    localparam int MAX_BP = 8;
    localparam logic [2:0] ALT_MAX_DUTY = 3'h3;

    // Control register layout, LSB last
    typedef struct packed {
        logic [12:0] rsvd;
        logic [3:0] trim;
        logic [2:0] blink_rate;
        logic blink_alt;
        logic blink_en;
        logic [2:0] duty;
        logic [2:0] prescale;
        logic wait_mode_disable;
        logic stop_mode_disable;
        logic src_alt;
        logic enable;
    } sld_ctrl_t;

    // Power mode request from the system controller
    typedef struct packed {
        logic stop2;
        logic stop3;
        logic wait_mode;
    } sld_pmode_t;

endpackage : sld_pkg

// ===== test/sld_driver_properties.sv
// Port-level checks for the segment display driver.
// Assumes it is bound to sld_driver and runs on its aclk domain.
`timescale 1ns/10ps
`default_nettype none
module sld_driver_properties
    import sld_pkg::*;
#(
    parameter int NPINS = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sld_pkg::sld_pmode_t pmode,
    input wire logic stop2_wakeup,
    input wire logic [NPINS-1:0] seg_out,
    input wire logic [NPINS-1:0] seg_oe,
    input wire logic [3:0] contrast_trim,
    input wire logic irq,
    input wire logic wake_req,
    input wire logic driver_active
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_aw_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_b_take;
        s_axi_bvalid && s_axi_bready;
    endsequence
    sequence s_r_take;
        s_axi_rvalid && s_axi_rready;
    endsequence

    aw_refuse_a: assert property (s_aw_take |=> !s_axi_awready)
        else $error("awready high right after address taken");
    b_release_a: assert property (s_b_take |=> !s_axi_bvalid)
        else $error("bvalid held after response taken");
    r_release_a: assert property (s_r_take |=> !s_axi_rvalid)
        else $error("rvalid held after read data taken");
    wake_stop2_a: assert property (pmode.stop2 |=> !wake_req)
        else $error("wake request raised in stop2");
    wake_stop3_a: assert property (
        $past(pmode.stop3) && !$past(pmode.stop2) |-> wake_req == irq)
        else $error("frame interrupt did not wake from stop3");
    wake_wait_a: assert property (
        $past(pmode.wait_mode) && !$past(pmode.stop2) |-> wake_req == irq)
        else $error("frame interrupt did not wake from wait");
    oe_halt_a: assert property (
        !driver_active |-> seg_oe == '0)
        else $error("pins driven while driver halted");
    out_halt_a: assert property (!driver_active |-> seg_out == '0)
        else $error("pin data nonzero while driver halted");
    out_mask_a: assert property ((seg_out & ~seg_oe) == '0)
        else $error("pin data on a pin that is not enabled");
    trim_wake_a: assert property (
        stop2_wakeup |-> ##2 contrast_trim == 4'h0)
        else $error("trim not back to default after stop2 wakeup");
endmodule : sld_driver_properties
`default_nettype wire

// ===== test/sld_panel_model.sv
// Clock sources seen from the driver's far side.
// Assumes the bench turns the time-of-day clock on before using it.
`timescale 1ns/10ps
`default_nettype none
module sld_panel_model #(
    parameter int OSC_HALF = 200,
    parameter int ALT_HALF = 300
) (
    input wire logic time_of_day_en,
    output logic external_osc_clock,
    output logic alternate_clock
);
    initial begin
        external_osc_clock = 1'b0;
        forever #(OSC_HALF) external_osc_clock = ~external_osc_clock;
    end
    // Time-of-day clock stands low unless the unit is set up to run it
    initial begin
        alternate_clock = 1'b0;
        forever begin
            #(ALT_HALF);
            if (time_of_day_en) begin
                alternate_clock = ~alternate_clock;
            end else begin
                alternate_clock = 1'b0;
            end
        end
    end
endmodule : sld_panel_model
`default_nettype wire

// ===== test/tb_segment_lcd_driver_power_modes.sv
// Self-checking bench for the segment display driver.
// Assumes sld_driver, its package, the checker and the panel model.
`timescale 1ns/10ps
`default_nettype none
module tb_segment_lcd_driver_power_modes;
    import sld_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0] rsp;
    } sld_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, stop2_wakeup;
    logic time_of_day_en;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb, contrast_trim;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic external_osc_clock, alternate_clock, irq, wake_req, driver_active;
    logic [63:0] seg_out, seg_oe;
    sld_pmode_t pmode;
    int errors = 0;
    int n_checks = 0;
    int ones = 0;
    sld_row_t rows [8] = '{
        '{32'h0, 32'h0007_8070, 32'h0007_8070, RESP_OKAY},
        '{32'hC, 32'h1, 32'h1, RESP_OKAY},
        '{32'h14, 32'hA5A5_0001, 32'hA5A5_0001, RESP_OKAY},
        '{32'h20, 32'h8000_0002, 32'h8000_0002, RESP_OKAY},
        '{32'h100, 32'hFF, 32'hFF, RESP_OKAY},
        '{32'h1FC, 32'h3C, 32'h3C, RESP_OKAY},
        '{32'h28, 32'h1, 32'h0, RESP_SLVERR},
        '{32'h1000, 32'h1, 32'h0, RESP_SLVERR}};

    sld_driver u_dut (.*);
    sld_panel_model u_panel (.*);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic summarize;
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rdat = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", e, rdat);
    endtask : rc

    initial begin
        #2_000_000;
        errors++;
        summarize();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, stop2_wakeup, time_of_day_en, aresetn} = 4'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        pmode = 3'h0;
        cyc(4);
        aresetn <= 1'b1;
        rc(32'h0, CTRL_RST);
        rc(32'h10, 32'h1);
        rc(32'hC, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", {30'h0, rows[i].rsp}, {30'h0, rsp});
            rd(rows[i].a);
            chk("rresp", {30'h0, rows[i].rsp}, {30'h0, rsp});
            if (rows[i].rsp == RESP_OKAY) chk("rdata", rows[i].q, rdat);
        end
        chk("trim", 32'hF, {28'h0, contrast_trim});
        wr(32'h14, 32'h1);
        wr(32'h0, 32'h181);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        chk("seg_oe", 32'h1, seg_oe[31:0]);
        chk("seg_out", 32'h1, seg_out[31:0]);
        wr(32'hC, 32'h0);
        cyc(3);
        chk("irq", 32'h0, {31'h0, irq});
        wr(32'hC, 32'h1);
        // Each row: power mode, hold-on control, halt control
        for (int m = 0; m < 3; m++) begin
            pmode <= sld_pmode_t'(3'h1 << m);
            wr(32'h0, 32'h181);
            cyc(3);
            chk("active", 32'h1, {31'h0, driver_active});
            chk("wake", 32'(m != 2), {31'h0, wake_req});
            wr(32'h0, m == 0 ? 32'h189 : 32'h185);
            cyc(3);
            chk("active", 32'h0, {31'h0, driver_active});
            chk("seg_oe", 32'h0, seg_oe[31:0]);
        end
        time_of_day_en <= 1'b1;
        wr(32'h0, 32'h183);
        cyc(20);
        wr(32'h8, 32'h1);
        cyc(200);
        rc(32'h4, 32'h0);
        pmode <= 3'h0;
        cyc(300);
        rc(32'h4, 32'h1);
        // Blink: blanking, then alternate bits, then a backplane ignoring it
        wr(32'h0, 32'h581);
        for (int i = 0; i < 400 && seg_out[0] !== 1'b0; i++) cyc(1);
        chk("blank", 32'h0, {31'h0, seg_out[0]});
        wr(32'h100, 32'hF0);
        wr(32'h0, 32'hD81);
        for (int i = 0; i < 400 && seg_out[0] !== 1'b1; i++) cyc(1);
        chk("alt", 32'h1, {31'h0, seg_out[0]});
        wr(32'h1C, 32'h1);
        cyc(3);
        repeat (300) begin
            @(posedge aclk);
            if (seg_out[0] !== 1'b0) ones++;
        end
        chk("bp_blink", 32'h0, ones);
        wr(32'h1C, 32'h0);
        wr(32'h100, 32'hFF);
        wr(32'h0, 32'h180);
        wr(32'h8, 32'h1);
        cyc(3);
        chk("irq", 32'h0, {31'h0, irq});
        rc(32'h4, 32'h0);
        wr(32'h0, 32'h0007_8185);
        @(posedge aclk);
        stop2_wakeup <= 1'b1;
        @(posedge aclk);
        stop2_wakeup <= 1'b0;
        rc(32'h0, CTRL_RST);
        rc(32'hC, 32'h0);
        rc(32'h14, 32'h1);
        rc(32'h100, 32'hFF);
        wr(32'hC, 32'h1);
        wr(32'h10, 32'h0);
        rc(32'h0, 32'h0);
        wr(32'h14, 32'h0);
        wr(32'h10, 32'h1);
        rc(32'h14, 32'h1);
        wr(32'h10, 32'h0);
        aresetn <= 1'b0;
        cyc(4);
        aresetn <= 1'b1;
        rc(32'h10, 32'h1);
        summarize();
    end
endmodule : tb_segment_lcd_driver_power_modes

bind sld_driver sld_driver_properties #(.NPINS(NPINS)) u_props (.*);
`default_nettype wire
